/* File: core/local_interrupt_ctrl_timer.sv */
// local interrupt controller with timer, arbitration priority and command interrupts
// Function
// R01 - disabled vectors masked, request stays set
// R02 - task priority too high gives spurious vector
// R03 - fixed/non-vectored accepted without arbitration
// R04 - focus processor always takes lowest-priority
// R05 - focus when in-service or request set
// R06 - otherwise lowest arbitration priority wins
// R07 - arbitration priority from task/request/service nibbles
// R08 - masking limits highest vectors to enabled
// R09 - command low write sends one interrupt
// R10 - 32-bit timer, bus clock divided
// R11 - initial count write loads current count
// R12 - zero count raises timer vector
// R13 - periodic mode reloads from initial count
// R14 - timer mask suppresses timer interrupts
// R15 - entries decode four message types
// R16 - hardware disabled accepts only non-vectored
// R17 - software disable ignored while hardware disabled
// R18 - INIT resets all but identifier; code keeps ipiOut and ipiValid through INIT
// R19 - only first external tick latched
// R20 - SMI entries trigger IO cycle, status
// R21 - service moves request to in-service; EOI clears
// R22 - one-shot stops at zero until rewritten
`timescale 1ns/1ps
module local_interrupt_ctrl_timer #(
   parameter int CNT_W = 32
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // configuration
   input wire logic hardwareEnableBit,
   input wire logic softwareEnableBit,
   input wire logic [7:0] spuriousVector,
   input wire logic focusCheckOff,
   input wire logic vectorEnableMaskingOn,
   input wire logic [255:0] perVectorEnableBits,
   input wire logic [7:0] taskPriority,
   input wire logic [7:0] controllerIdentifier,
   // timer programming
   input wire lic_pkg::lvt_entry_t timerVectorEntry,
   input wire logic [7:0] timerDivideConfig,
   input wire logic initCountWr,
   input wire logic [CNT_W-1:0] initCountData,
   // command registers
   input wire logic commandLowWr,
   input wire lic_pkg::ipi_msg_t commandMsg,
   // incoming messages from fabric
   input wire logic msgValid,
   input wire lic_pkg::ipi_msg_t msgIn,
   input wire logic msgLowestPrio,
   input wire logic msgInit,
   input wire logic arbWon,
   // core side
   input wire logic serviceReq,
   input wire logic eoiWr,
   // outputs
   output logic [CNT_W-1:0] timerCurrentCount,
   output logic [7:0] arbPriority,
   output logic focusHit,
   output logic [255:0] pendingRequestBits,
   output logic [255:0] inServiceBitsA,
   output logic serviceValid,
   output logic [7:0] serviceVector,
   output logic serviceSpurious,
   output logic nmiOut,
   output logic extIntOut,
   output lic_pkg::ipi_msg_t ipiOut,
   output logic ipiValid,
   output logic smiIoCycle,
   output logic [31:0] localSmiStatus
);

   // highest set bit index
   function automatic logic [7:0] highest(input logic [255:0] v);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < 256; i++) begin
         if (v[i]) begin
            r = 8'(i);
         end
      end
      return r;
   endfunction

   // true when an entry carries the given message type
   function automatic logic typeIs(input lic_pkg::lvt_entry_t e, input logic [2:0] t);
      return e.msgType == t;
   endfunction

   logic rstMeta, rstSync;
   logic [1:0] hwSync, swSync;
   logic hwEn, swEn, initMeta, initSync;
   logic [CNT_W-1:0] count_r;
   logic [7:0] divCnt_r;
   logic divTick;
   lic_pkg::tmr_state_t tmrState_r;
   logic timerFire;
   logic [255:0] irr_r, isr_r;
   logic [255:0] irrEff, isrEff;
   logic [7:0] highest_request_vector, highest_service_vector, apr;
   logic lvtAccept, extLatched_r;
   logic msgAccept, ctrlOn;
   logic [CNT_W-1:0] initCount_r;
   logic tmrFixed, tmrSmi, tmrNmi, tmrExt;
   logic [7:0] eoiVec;

   // reset release
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rstMeta <= 1'b0;
         rstSync <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstSync <= rstMeta;
      end
   end

   // enable and init synchronisers
   always_ff @(posedge clk_sys or negedge rstSync) begin
      if (!rstSync) begin
         hwSync <= 2'b00;
         swSync <= 2'b00;
         initMeta <= 1'b0;
         initSync <= 1'b0;
      end else begin
         hwSync <= {hwSync[0], hardwareEnableBit};
         swSync <= {swSync[0], softwareEnableBit};
         initMeta <= msgInit;
         initSync <= initMeta;
      end
   end
   assign hwEn = hwSync[1];
   assign swEn = swSync[1];
   // software disable only matters when hardware enabled
   assign ctrlOn = hwEn && swEn; // [R16] [R17]

   // masking and highest vectors
   assign irrEff = vectorEnableMaskingOn ? (irr_r & perVectorEnableBits) : irr_r; // [R01] [R08]
   assign isrEff = vectorEnableMaskingOn ? (isr_r & perVectorEnableBits) : isr_r; // [R08]
   assign highest_request_vector = highest(irrEff);
   assign highest_service_vector = highest(isrEff);
   // end of interrupt retires the highest in-service bit, masked or not
   assign eoiVec = highest(isr_r); // [R21]

   always_comb begin
      if (taskPriority[7:4] >= highest_request_vector[7:4] && taskPriority[7:4] > highest_service_vector[7:4]) begin
         apr = taskPriority; // [R07]
      end else if (highest_request_vector[7:4] > highest_service_vector[7:4]) begin
         apr = {highest_request_vector[7:4], 4'h0}; // [R07]
      end else begin
         apr = {highest_service_vector[7:4], 4'h0}; // [R07]
      end
   end

   // focus check on the arriving vector
   always_comb begin
      focusHit = (isr_r[msgIn.vector] || irr_r[msgIn.vector]) &&
         (!vectorEnableMaskingOn || perVectorEnableBits[msgIn.vector]) && !focusCheckOff; // [R05]
   end

   // divider tick
   always_ff @(posedge clk_sys or negedge rstSync) begin
      if (!rstSync) begin
         divCnt_r <= 8'h00;
      end else if (initSync || divTick) begin
         divCnt_r <= 8'h00;
      end else begin
         divCnt_r <= divCnt_r + 8'h01;
      end
   end
   assign divTick = (divCnt_r + 8'h01 >= ((timerDivideConfig == 8'h00) ? lic_pkg::DIV_RST : timerDivideConfig)); // [R10]

   // timer
   always_ff @(posedge clk_sys or negedge rstSync) begin
      if (!rstSync) begin
         count_r <= CNT_W'(lic_pkg::COUNT_RST);
         initCount_r <= CNT_W'(lic_pkg::COUNT_RST);
         tmrState_r <= lic_pkg::TMR_IDLE;
         timerFire <= 1'b0;
      end else if (initSync) begin
         count_r <= CNT_W'(lic_pkg::COUNT_RST); // [R18]
         initCount_r <= CNT_W'(lic_pkg::COUNT_RST);
         tmrState_r <= lic_pkg::TMR_IDLE;
         timerFire <= 1'b0;
      end else begin
         timerFire <= 1'b0;
         if (initCountWr) begin
            count_r <= initCountData; // [R11]
            initCount_r <= initCountData;
            tmrState_r <= (initCountData == '0) ? lic_pkg::TMR_IDLE : lic_pkg::TMR_RUN;
         end else begin
            case (tmrState_r)
               lic_pkg::TMR_RUN: begin
                  if (divTick) begin
                     if (count_r == CNT_W'(1)) begin
                        timerFire <= !timerVectorEntry.mask; // [R12] [R14]
                        if (timerVectorEntry.periodic) begin
                           // reload from the written value, not the live data bus
                           count_r <= initCount_r; // [R13]
                        end else begin
                           count_r <= '0; // [R22]
                           tmrState_r <= lic_pkg::TMR_DONE;
                        end
                     end else begin
                        count_r <= count_r - CNT_W'(1); // [R11]
                     end
                  end
               end
               lic_pkg::TMR_DONE: tmrState_r <= lic_pkg::TMR_DONE; // [R22]
               default: tmrState_r <= lic_pkg::TMR_IDLE;
            endcase
         end
      end
   end
   assign timerCurrentCount = count_r;

   // incoming message acceptance
   always_comb begin
      msgAccept = 1'b0;
      if (msgValid && (msgIn.msgType == lic_pkg::MSG_FIXED) && ctrlOn) begin
         msgAccept = msgLowestPrio ? (focusHit || arbWon) : 1'b1; // [R03] [R04] [R06]
      end
   end

   // timer entry message type decode
   assign tmrFixed = timerFire && typeIs(timerVectorEntry, lic_pkg::MSG_FIXED); // [R15]
   assign tmrSmi = timerFire && typeIs(timerVectorEntry, lic_pkg::MSG_SMI); // [R15]
   assign tmrNmi = timerFire && typeIs(timerVectorEntry, lic_pkg::MSG_NMI); // [R15]
   assign tmrExt = timerFire && typeIs(timerVectorEntry, lic_pkg::MSG_EXTERNAL_INTERRUPT_TYPE); // [R15]
   assign lvtAccept = tmrFixed && ctrlOn; // [R16]

   // request and in-service bits
   always_ff @(posedge clk_sys or negedge rstSync) begin
      if (!rstSync) begin
         irr_r <= '0;
         isr_r <= '0;
      end else if (initSync) begin
         irr_r <= '0; // [R18]
         isr_r <= '0;
      end else begin
         logic [255:0] irrN, isrN;
         irrN = irr_r;
         isrN = isr_r;
         if (eoiWr && isr_r != '0) begin
            isrN[eoiVec] = 1'b0; // [R21]
         end
         if (serviceReq && irrEff != '0 && taskPriority[7:4] < highest_request_vector[7:4]) begin
            irrN[highest_request_vector] = 1'b0; // [R21]
            isrN[highest_request_vector] = 1'b1;
         end
         if (msgAccept && msgIn.vector >= lic_pkg::VEC_MIN) begin
            irrN[msgIn.vector] = 1'b1;
         end
         if (lvtAccept && timerVectorEntry.vector >= lic_pkg::VEC_MIN) begin
            irrN[timerVectorEntry.vector] = 1'b1; // [R12]
         end
         irr_r <= irrN;
         isr_r <= isrN;
      end
   end
   assign pendingRequestBits = irr_r;
   assign inServiceBitsA = isr_r;

   // service delivery to the core
   always_ff @(posedge clk_sys or negedge rstSync) begin
      if (!rstSync) begin
         serviceValid <= 1'b0;
         serviceVector <= 8'h00;
         serviceSpurious <= 1'b0;
      end else if (initSync) begin
         serviceValid <= 1'b0; // [R18]
         serviceVector <= 8'h00;
         serviceSpurious <= 1'b0;
      end else begin
         serviceValid <= serviceReq && irrEff != '0;
         if (serviceReq && irrEff != '0) begin
            if (taskPriority[7:4] >= highest_request_vector[7:4]) begin
               serviceVector <= spuriousVector; // [R02]
               serviceSpurious <= 1'b1;
            end else begin
               serviceVector <= highest_request_vector; // [R01]
               serviceSpurious <= 1'b0;
            end
         end else begin
            serviceSpurious <= 1'b0;
         end
      end
   end

   // non-vectored outputs, external latch, smi path
   always_ff @(posedge clk_sys or negedge rstSync) begin
      if (!rstSync) begin
         nmiOut <= 1'b0;
         extLatched_r <= 1'b0;
         smiIoCycle <= 1'b0;
         localSmiStatus <= 32'h0;
      end else if (initSync) begin
         nmiOut <= 1'b0;
         extLatched_r <= 1'b0;
         smiIoCycle <= 1'b0;
         localSmiStatus <= 32'h0; // [R18]
      end else begin
         nmiOut <= tmrNmi ||
            (msgValid && msgIn.msgType == lic_pkg::MSG_NMI); // [R15] [R16]
         if (tmrExt) begin
            extLatched_r <= 1'b1; // [R19]
         end else if (serviceReq && extLatched_r) begin
            extLatched_r <= 1'b0;
         end
         smiIoCycle <= tmrSmi; // [R20]
         if (tmrSmi) begin
            localSmiStatus[lic_pkg::SMI_STS_LVT_BIT] <= 1'b1; // [R20]
         end
      end
   end
   assign extIntOut = extLatched_r;

   // command interrupt
   always_ff @(posedge clk_sys or negedge rstSync) begin
      if (!rstSync) begin
         ipiValid <= 1'b0;
         ipiOut <= '0;
         arbPriority <= 8'h00;
      end else begin
         ipiValid <= commandLowWr; // [R09]
         if (commandLowWr) begin
            ipiOut <= commandSelf(commandMsg, controllerIdentifier); // [R09]
         end
         arbPriority <= initSync ? 8'h00 : apr; // [R06]
      end
   end

   // self targets use own identifier
   function automatic lic_pkg::ipi_msg_t commandSelf(input lic_pkg::ipi_msg_t m, input logic [7:0] id);
      lic_pkg::ipi_msg_t r;
      r = m;
      if (m.selfOnly) begin
         r.dest = id;
      end
      return r;
   endfunction
endmodule

/* File: pkg/lic_pkg.sv */
// package for the local interrupt controller and timer
package lic_pkg;
   // local vector entry message types
   localparam logic [2:0] MSG_FIXED = 3'h0;
   localparam logic [2:0] MSG_SMI = 3'h2;
   localparam logic [2:0] MSG_NMI = 3'h4;
   localparam logic [2:0] MSG_EXTERNAL_INTERRUPT_TYPE = 3'h7;
   // vectors 15..0 reserved
   localparam logic [7:0] VEC_MIN = 8'h10;
   // reset values
   localparam logic [7:0] SPURIOUS_RST = 8'hff;
   localparam logic [31:0] COUNT_RST = 32'h0;
   localparam logic [7:0] DIV_RST = 8'h01;
   // local smi status bit for legacy entries
   localparam int SMI_STS_LVT_BIT = 16;

   typedef struct packed {
      logic mask;
      logic periodic;
      logic [2:0] msgType;
      logic [7:0] vector;
   } lvt_entry_t;

   typedef struct packed {
      logic [2:0] msgType;
      logic [7:0] vector;
      logic [7:0] dest;
      logic selfOnly;
   } ipi_msg_t;

   typedef enum logic [1:0] {
      TMR_IDLE = 2'b00,
      TMR_RUN = 2'b01,
      TMR_DONE = 2'b10
   } tmr_state_t;
endpackage

/* File: sim/fabric_model.sv */
// far-side fabric model: delivers messages, arbitrates against a rival
`timescale 1ns/1ps
module fabric_model (
   // clock and identity
   input wire logic clk_sys,
   input wire logic [7:0] ownId,
   // arbitration
   input wire logic [7:0] arbPriority,
   input wire logic [7:0] rivalPrio,
   output logic arbWon,
   // message delivery
   output logic msgValid,
   output lic_pkg::ipi_msg_t msgIn,
   output logic msgLowestPrio
);
   assign arbWon = arbPriority < rivalPrio;
   initial begin
      msgValid = 1'b0;
      msgIn = '0;
      msgLowestPrio = 1'b0;
   end
   task automatic send(input logic [2:0] t, input logic [7:0] v, input logic lp);
      @(posedge clk_sys);
      msgIn <= '{t, v, ownId, 1'b0};
      msgLowestPrio <= lp;
      msgValid <= 1'b1;
      @(posedge clk_sys);
      msgValid <= 1'b0;
      msgIn <= ~msgIn;
      msgLowestPrio <= ~lp;
   endtask
endmodule

/* File: sim/local_interrupt_ctrl_timer_chk.sv */
// port assertions for the local interrupt controller and timer
`timescale 1ns/1ps
module local_interrupt_ctrl_timer_chk #(
   parameter int CNT_W = 32
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // stimulus side
   input wire lic_pkg::lvt_entry_t timerVectorEntry,
   input wire logic [7:0] timerDivideConfig,
   input wire logic [7:0] spuriousVector,
   input wire logic initCountWr,
   input wire logic [CNT_W-1:0] initCountData,
   input wire logic commandLowWr,
   input wire lic_pkg::ipi_msg_t commandMsg,
   input wire logic msgInit,
   input wire logic eoiWr,
   input wire logic [7:0] controllerIdentifier,
   input wire logic focusCheckOff,
   input wire lic_pkg::ipi_msg_t msgIn,
   // design outputs
   input wire logic [CNT_W-1:0] timerCurrentCount,
   input wire logic [255:0] inServiceBitsA,
   input wire logic [255:0] pendingRequestBits,
   input wire logic focusHit,
   input wire logic serviceValid,
   input wire logic [7:0] serviceVector,
   input wire logic serviceSpurious,
   input wire lic_pkg::ipi_msg_t ipiOut,
   input wire logic ipiValid
);
   logic [CNT_W-1:0] initCopy_r;
   lic_pkg::ipi_msg_t expIpi;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);
   // last written initial count
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         initCopy_r <= '0;
      end else if (initCountWr) begin
         initCopy_r <= initCountData;
      end
   end
   // self-targeted commands carry the own identifier
   always_comb begin
      expIpi = commandMsg;
      if (commandMsg.selfOnly) begin
         expIpi.dest = controllerIdentifier;
      end
   end
   a_ipi_follows_write: assert property (commandLowWr |=> ipiValid && ipiOut == $past(expIpi))
      else $error("command interrupt missing or wrong");
   a_ipi_only_cmd: assert property (ipiValid |-> $past(commandLowWr))
      else $error("command interrupt without write");
   a_count_load: assert property (initCountWr && !msgInit |=> timerCurrentCount == $past(initCountData))
      else $error("initial count not loaded");
   a_count_down_step: assert property (timerDivideConfig == 8'h01 && timerCurrentCount > 1 && !initCountWr
      && !msgInit |=> timerCurrentCount == $past(timerCurrentCount) - 1'b1)
      else $error("count did not step down");
   a_oneshot_stays_zero: assert property (!timerVectorEntry.periodic && timerCurrentCount == 0
      && !initCountWr |=> timerCurrentCount == 0)
      else $error("one-shot count left zero");
   a_periodic_reload: assert property (timerVectorEntry.periodic && timerCurrentCount == 1
      && timerDivideConfig == 8'h01 && !initCountWr && !msgInit |=> timerCurrentCount == initCopy_r)
      else $error("periodic reload wrong");
   a_spurious_vector: assert property (serviceValid && serviceSpurious |-> serviceVector == spuriousVector)
      else $error("spurious vector wrong");
   a_spurious_keeps_isr: assert property (serviceValid && serviceSpurious && !$past(eoiWr)
      |-> $stable(inServiceBitsA))
      else $error("spurious changed in-service bits");
   a_focus_off_none: assert property (focusCheckOff |-> !focusHit)
      else $error("focus reported while focus check off");
   a_focus_needs_bit: assert property (focusHit
      |-> inServiceBitsA[msgIn.vector] || pendingRequestBits[msgIn.vector])
      else $error("focus without request or in-service bit");
   c_focus: cover property (focusHit);
   c_spurious: cover property (serviceValid && serviceSpurious);
   c_ipi: cover property (ipiValid);
   c_reload: cover property (timerVectorEntry.periodic && timerCurrentCount == 1);
endmodule
bind local_interrupt_ctrl_timer local_interrupt_ctrl_timer_chk #(.CNT_W(CNT_W)) local_interrupt_ctrl_timer_chk_inst (
   .clk_sys, .nrst, .timerVectorEntry, .timerDivideConfig, .spuriousVector, .initCountWr, .initCountData,
   .commandLowWr, .commandMsg, .msgInit, .eoiWr, .controllerIdentifier, .focusCheckOff, .msgIn,
   .timerCurrentCount, .inServiceBitsA, .pendingRequestBits, .focusHit, .serviceValid,
   .serviceVector, .serviceSpurious, .ipiOut, .ipiValid);

/* File: sim/tb_local_interrupt_ctrl_timer.sv */
// self-checking bench for the local interrupt controller and timer
`timescale 1ns/1ps
module tb_local_interrupt_ctrl_timer;
   logic clk_sys = 1'b0, nrst = 1'b0, hardwareEnableBit = 1'b1, softwareEnableBit = 1'b1, focusCheckOff = 1'b0;
   logic vectorEnableMaskingOn = 1'b0, initCountWr = 1'b0, commandLowWr = 1'b0, msgInit = 1'b0, serviceReq = 1'b0;
   logic eoiWr = 1'b0, msgValid, msgLowestPrio, arbWon, focusHit, serviceValid, serviceSpurious;
   logic nmiOut, extIntOut, ipiValid, smiIoCycle;
   logic [1:0] seen = 2'h0;
   logic [7:0] spuriousVector = 8'h0f, taskPriority = 8'h00, controllerIdentifier = 8'h03, timerDivideConfig = 8'h01;
   logic [7:0] rivalPrio = 8'h00, arbPriority, serviceVector, v;
   logic [31:0] initCountData = 32'h0, timerCurrentCount, localSmiStatus;
   logic [255:0] perVectorEnableBits = '1, pendingRequestBits, inServiceBitsA, expIrr = '0, expIsr = '0;
   logic [2:0] ty [4] = '{lic_pkg::MSG_FIXED, lic_pkg::MSG_SMI, lic_pkg::MSG_NMI, lic_pkg::MSG_EXTERNAL_INTERRUPT_TYPE};
   lic_pkg::lvt_entry_t timerVectorEntry = '0;
   lic_pkg::ipi_msg_t commandMsg = '0, msgIn, ipiOut;
   int seed = 32'h57bf8c04, miscompares = 0, num_checks = 0, cyc = 0, nmiCnt = 0, n;
   local_interrupt_ctrl_timer #(.CNT_W(32)) local_interrupt_ctrl_timer_inst (.clk_sys, .nrst, .hardwareEnableBit,
      .softwareEnableBit, .spuriousVector, .focusCheckOff, .vectorEnableMaskingOn, .perVectorEnableBits, .taskPriority,
      .controllerIdentifier, .timerVectorEntry, .timerDivideConfig, .initCountWr, .initCountData, .commandLowWr,
      .commandMsg, .msgValid, .msgIn, .msgLowestPrio, .msgInit, .arbWon, .serviceReq, .eoiWr, .timerCurrentCount,
      .arbPriority, .focusHit, .pendingRequestBits, .inServiceBitsA, .serviceValid, .serviceVector, .serviceSpurious,
      .nmiOut, .extIntOut, .ipiOut, .ipiValid, .smiIoCycle, .localSmiStatus);
   fabric_model fabric_model_inst (.clk_sys, .ownId(controllerIdentifier), .arbPriority, .rivalPrio, .arbWon,
      .msgValid, .msgIn, .msgLowestPrio);
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      seen <= seen | {extIntOut, smiIoCycle};
      nmiCnt <= nmiCnt + (nmiOut === 1'b1);
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         stop_test();
      end
   end
   function automatic logic [7:0] hi(input logic [255:0] b);
      hi = 8'h00;
      for (int i = 0; i < 256; i++)
         if (b[i])
            hi = i[7:0];
   endfunction
   function automatic logic [7:0] apr(input logic [7:0] tp, input logic [255:0] irr, input logic [255:0] isr);
      logic [7:0] rv;
      logic [7:0] sv;
      rv = hi(irr);
      sv = hi(isr);
      if (tp[7:4] >= rv[7:4] && tp[7:4] > sv[7:4])
         apr = tp;
      else if (rv[7:4] > sv[7:4])
         apr = {rv[7:4], 4'h0};
      else
         apr = {sv[7:4], 4'h0};
   endfunction
   function automatic lic_pkg::ipi_msg_t ipiExp(input lic_pkg::ipi_msg_t m, input logic [7:0] id);
      ipiExp = m;
      if (m.selfOnly)
         ipiExp.dest = id;
   endfunction
   task automatic tick(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask
   task automatic chk(input logic [255:0] got, input logic [255:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic load(input logic [31:0] c);
      @(posedge clk_sys);
      initCountData <= c;
      initCountWr <= 1'b1;
      @(posedge clk_sys);
      initCountWr <= 1'b0;
   endtask
   task automatic serve();
      v = hi(expIrr);
      @(posedge clk_sys);
      serviceReq <= 1'b1;
      @(posedge clk_sys);
      serviceReq <= 1'b0;
      #1;
      chk(serviceValid, !vectorEnableMaskingOn && expIrr != '0);
      if (vectorEnableMaskingOn) begin
         chk(pendingRequestBits, expIrr);
      end else if (taskPriority[7:4] >= v[7:4]) begin
         chk(serviceVector, spuriousVector);
      end else begin
         expIrr[v] = 1'b0;
         expIsr[v] = 1'b1;
         chk(serviceVector, v);
      end
      chk(inServiceBitsA, expIsr);
   endtask
   task automatic stop_test();
      $display("checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      tick(4);
      nrst <= 1'b1;
      tick(6);
      spuriousVector <= 8'($random(seed));
      taskPriority <= 8'($random(seed));
      for (int i = 0; i < 6; i++) begin
         @(posedge clk_sys);
         commandMsg <= 20'($random(seed));
         commandLowWr <= 1'b1;
         @(posedge clk_sys);
         commandLowWr <= 1'b0;
         #1 chk(ipiOut, ipiExp(commandMsg, controllerIdentifier));
      end
      for (int i = 0; i < 4; i++) begin
         v = {1'b0, 7'($random(seed))} | 8'h10;
         fabric_model_inst.send(lic_pkg::MSG_FIXED, v, 1'b0);
         expIrr[v] = 1'b1;
      end
      tick(3);
      chk(pendingRequestBits, expIrr);
      chk(arbPriority, apr(taskPriority, expIrr, expIsr));
      taskPriority <= 8'h00;
      serve();
      // focus check off: in-service vector refused when arbitration lost
      focusCheckOff <= 1'b1;
      fabric_model_inst.send(lic_pkg::MSG_FIXED, v, 1'b1);
      tick(2);
      chk(pendingRequestBits, expIrr);
      focusCheckOff <= 1'b0;
      // focus by in-service bit, then plain arbitration lost and won
      fabric_model_inst.send(lic_pkg::MSG_FIXED, v, 1'b1);
      fabric_model_inst.send(lic_pkg::MSG_FIXED, 8'h12, 1'b1);
      expIrr[v] = 1'b1;
      tick(3);
      chk(pendingRequestBits, expIrr);
      rivalPrio <= 8'hff;
      fabric_model_inst.send(lic_pkg::MSG_FIXED, 8'h12, 1'b1);
      expIrr[8'h12] = 1'b1;
      @(posedge clk_sys);
      eoiWr <= 1'b1;
      @(posedge clk_sys);
      eoiWr <= 1'b0;
      expIsr[hi(expIsr)] = 1'b0;
      tick(3);
      chk(pendingRequestBits, expIrr);
      chk(inServiceBitsA, expIsr);
      taskPriority <= 8'hf0;
      serve();
      vectorEnableMaskingOn <= 1'b1;
      perVectorEnableBits <= '0;
      taskPriority <= 8'h00;
      tick(3);
      chk(arbPriority, apr(taskPriority, '0, '0));
      serve();
      vectorEnableMaskingOn <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         timerVectorEntry <= '{1'b0, 1'b0, ty[k], 8'h80};
         load(32'h2);
         tick(8);
         chk(timerCurrentCount, 0);
      end
      expIrr[8'h80] = 1'b1;
      chk(pendingRequestBits, expIrr);
      chk({seen, localSmiStatus[lic_pkg::SMI_STS_LVT_BIT]}, 3'h7);
      chk(nmiCnt, 1);
      timerVectorEntry <= '{1'b1, 1'b0, lic_pkg::MSG_FIXED, 8'h90};
      load(32'h2);
      tick(8);
      chk(pendingRequestBits, expIrr);
      timerVectorEntry <= '{1'b0, 1'b1, lic_pkg::MSG_FIXED, 8'ha0};
      load(32'h3);
      tick(9);
      chk(timerCurrentCount != 0, 1);
      timerVectorEntry <= '{1'b1, 1'b1, lic_pkg::MSG_FIXED, 8'ha0};
      load(32'h0);
      timerDivideConfig <= 8'h04;
      timerVectorEntry <= '{1'b0, 1'b1, lic_pkg::MSG_FIXED, 8'hb0};
      load(32'h3);
      n = 0;
      while (pendingRequestBits[8'hb0] !== 1'b1 && n < 40) begin
         tick(1);
         n++;
      end
      chk(n >= 9 && n <= 16, 1);
      timerVectorEntry <= '{1'b1, 1'b0, lic_pkg::MSG_FIXED, 8'hb0};
      load(32'hffff);
      msgInit <= 1'b1;
      tick(6);
      msgInit <= 1'b0;
      tick(4);
      chk(pendingRequestBits, 0);
      chk(inServiceBitsA, 0);
      chk({timerCurrentCount, localSmiStatus}, 0);
      softwareEnableBit <= 1'b0;
      tick(4);
      fabric_model_inst.send(lic_pkg::MSG_FIXED, 8'h30, 1'b0);
      tick(4);
      chk(pendingRequestBits, 0);
      softwareEnableBit <= 1'b1;
      hardwareEnableBit <= 1'b0;
      tick(4);
      fabric_model_inst.send(lic_pkg::MSG_FIXED, 8'h20, 1'b0);
      fabric_model_inst.send(lic_pkg::MSG_NMI, 8'h20, 1'b0);
      tick(4);
      chk(pendingRequestBits, 0);
      chk(nmiCnt, 2);
      stop_test();
   end
endmodule
